//--- logic/rpi_pkg.sv
// constants for the pending-interrupt flag logic of the remote terminal
// assumes one clock domain and a host that reads registers by offset
package rpi_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] PENDING_OFFSET = 16'h0006;
  localparam logic [15:0] PENDING_RESET  = 16'h0000;

  // ---------------------------------------------------------------
  // flag bit positions
  // ---------------------------------------------------------------
  localparam int BIT_INDEX_ZERO    = 15;
  localparam int BIT_SUBADDR_ACC   = 14;
  localparam int BIT_BROADCAST_RX  = 13;
  localparam int BIT_MESSAGE_ERROR = 10;
  localparam int BIT_ILLEGAL_CMD   = 8;
  localparam int BIT_SERIAL_FRAME  = 7;
  localparam int BIT_LOOPBACK_A    = 6;
  localparam int BIT_LOOPBACK_B    = 5;
  localparam int BIT_TIMETAG_MATCH = 4;
  localparam int BIT_TIMETAG_WRAP  = 3;
  localparam int BIT_ADDR_PARITY   = 2;
  localparam int BIT_ROM_CHECKSUM  = 1;
  localparam int BIT_RAM_VERIFY    = 0;

  // ---------------------------------------------------------------
  // category masks
  // ---------------------------------------------------------------
  localparam logic [15:0] FLAG_IMPL_MASK  = 16'hE5FF; // bits 12,11,9 unused
  localparam logic [15:0] MESSAGE_MASK    = 16'hE560;
  localparam logic [15:0] HARDWARE_MASK   = 16'h009F;
  localparam logic [15:0] ALWAYS_EN_MASK  = 16'h0007;

  // ---------------------------------------------------------------
  // time tag and log
  // ---------------------------------------------------------------
  localparam logic [15:0] TIMETAG_MAX = 16'hFFFF;
  localparam logic [15:0] TIMETAG_MIN = 16'h0000;
  localparam int          LOG_DEPTH   = 16;
  localparam int          LOG_AW      = 4;
  localparam logic [3:0]  LOG_PTR_RESET = 4'h0;

endpackage

//--- logic/rpi_log.sv
// interrupt log: keeps the last sixteen sets of newly raised flags
// assumes entry_stb is a one-cycle pulse from the flag logic
`timescale 1ns/1ns
`default_nettype none
module rpi_log (
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  input  wire logic                           entry_stb,
  input  wire logic [15:0]                    entry_data,
  input  wire logic [rpi_pkg::LOG_AW-1:0]     rd_idx,
  output logic      [15:0]                    rd_data,
  output logic      [rpi_pkg::LOG_AW-1:0]     wr_ptr
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0]                mem_q [rpi_pkg::LOG_DEPTH];
  logic [rpi_pkg::LOG_AW-1:0] ptr_q;

  // write pointer wraps, so the oldest entry is overwritten first
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= rpi_pkg::LOG_PTR_RESET;
    end else if (entry_stb) begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  // memory has no reset: contents are only meaningful once written
  always_ff @(posedge clk_sys) begin
    if (entry_stb) begin
      mem_q[ptr_q] <= entry_data;
    end
  end

  // registered read port, one cycle of latency
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= mem_q[rd_idx];
    end
  end

  assign wr_ptr = ptr_q;

endmodule
`default_nettype wire

//--- logic/rpi_flags.sv
// pending-interrupt flag register, interrupt outputs and log feed
// assumes event inputs are one-cycle pulses synchronous to clk_sys;
// resetn is the master reset, soft_reset never touches the flags
//
// How it works
// [R1] enabled event sets flag and logs entry
// [R2] flag category picks message or hardware output
// [R3] disabled event: no flag, output, log
// [R4] host read returns contents, then clears all
// [R5] master reset clears; software reset ignored
// [R6] index zero or circular count sets bit15
// [R7] subaddress access sets bit14
// [R8] broadcast message received sets bit13
// [R9] message error sets bit10
// [R10] illegal command sets bit8
// [R11] serial host framing fault sets bit7
// [R12] loopback mismatch sets bit6 or bit5
// [R13] time-tag match sets bit4
// [R14] time-tag wrap sets bit3
// [R15] bad address parity sets bit2, always
// [R16] parity fault blocks terminal start
// [R17] checksum fault sets bit1, always
// [R18] ram verify fault sets bit0, always
// [R19] init faults set test word bit1
// [R20] unused bits zero; set beats clear
`timescale 1ns/1ns
`default_nettype none
module rpi_flags (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        soft_reset,
  input  wire logic        host_rd_stb,
  input  wire logic [15:0] host_addr,
  output logic      [15:0] host_rd_data,
  output logic             host_rd_valid,
  input  wire logic [15:0] irq_enable,
  input  wire logic        index_step_zero_evt,
  input  wire logic        circular_done_evt,
  input  wire logic        cw_allow_index_zero,
  input  wire logic        subaddr_access_evt,
  input  wire logic        cw_allow_subaddr,
  input  wire logic        broadcast_rx_evt,
  input  wire logic        cw_allow_broadcast,
  input  wire logic        message_error_evt,
  input  wire logic        illegal_command_evt,
  input  wire logic        serial_host_variant,
  input  wire logic        host_serial_frame_fault,
  input  wire logic        loopback_a_stb,
  input  wire logic [15:0] loopback_a_sent,
  input  wire logic [15:0] loopback_a_echo,
  input  wire logic        loopback_b_stb,
  input  wire logic [15:0] loopback_b_sent,
  input  wire logic [15:0] loopback_b_echo,
  input  wire logic [15:0] timetag_count,
  input  wire logic [15:0] timetag_utility,
  input  wire logic [5:0]  term_addr_bits,
  input  wire logic        start_execution_bit,
  input  wire logic        rom_checksum_fault,
  input  wire logic        ram_verify_fault,
  output logic             message_irq_out,
  output logic             hardware_irq_out,
  output logic             terminal_run,
  output logic             bit_word_init_fail,
  input  wire logic [3:0]  log_rd_idx,
  output logic      [15:0] log_rd_data,
  output logic      [3:0]  log_wr_ptr
);

  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  logic [15:0] raw_evt;
  logic [15:0] eff_en;
  logic [15:0] set_vec;
  logic [15:0] flags_q;
  logic [15:0] flags_d;
  logic [15:0] timetag_prev_q;
  logic        parity_bad;
  logic        parity_bad_q;
  logic        rd_hit;
  logic        log_stb_q;
  logic [15:0] log_data_q;
  logic        init_fail_q;

  // odd count of ones over address and parity is the healthy case
  assign parity_bad = ~(^term_addr_bits); // [R15]

  // host read decode
  assign rd_hit = host_rd_stb && (host_addr == rpi_pkg::PENDING_OFFSET);

  // raw event vector, one bit per flag position
  always_comb begin
    raw_evt = 16'h0000;
    raw_evt[rpi_pkg::BIT_INDEX_ZERO] = (index_step_zero_evt || circular_done_evt)
                                       && cw_allow_index_zero; // [R6]
    raw_evt[rpi_pkg::BIT_SUBADDR_ACC] = subaddr_access_evt && cw_allow_subaddr; // [R7]
    raw_evt[rpi_pkg::BIT_BROADCAST_RX] = broadcast_rx_evt && cw_allow_broadcast; // [R8]
    raw_evt[rpi_pkg::BIT_MESSAGE_ERROR] = message_error_evt; // [R9]
    raw_evt[rpi_pkg::BIT_ILLEGAL_CMD] = illegal_command_evt; // [R10]
    raw_evt[rpi_pkg::BIT_SERIAL_FRAME] = serial_host_variant
                                         && host_serial_frame_fault; // [R11]
    raw_evt[rpi_pkg::BIT_LOOPBACK_A] = loopback_a_stb
                                       && (loopback_a_sent != loopback_a_echo); // [R12]
    raw_evt[rpi_pkg::BIT_LOOPBACK_B] = loopback_b_stb
                                       && (loopback_b_sent != loopback_b_echo); // [R12]
    // count is compared on arrival only, so a stopped counter fires once
    raw_evt[rpi_pkg::BIT_TIMETAG_MATCH] = (timetag_count == timetag_utility)
                                          && (timetag_prev_q != timetag_utility); // [R13]
    raw_evt[rpi_pkg::BIT_TIMETAG_WRAP] = (timetag_prev_q == rpi_pkg::TIMETAG_MAX)
                                         && (timetag_count == rpi_pkg::TIMETAG_MIN); // [R14]
    raw_evt[rpi_pkg::BIT_ADDR_PARITY] = parity_bad && !parity_bad_q; // [R15]
    raw_evt[rpi_pkg::BIT_ROM_CHECKSUM] = rom_checksum_fault; // [R17]
    raw_evt[rpi_pkg::BIT_RAM_VERIFY] = ram_verify_fault; // [R18]
  end

  // three sources are enabled whatever software writes; unused bits never set
  assign eff_en  = (irq_enable | rpi_pkg::ALWAYS_EN_MASK) & rpi_pkg::FLAG_IMPL_MASK; // [R20]
  assign set_vec = raw_evt & eff_en; // [R3]

  // history for edge and wrap detection
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timetag_prev_q <= rpi_pkg::TIMETAG_MIN;
      parity_bad_q   <= 1'b0;
    end else begin
      timetag_prev_q <= timetag_count;
      parity_bad_q   <= parity_bad;
    end
  end

  // ---------------------------------------------------------------
  // flag register
  // ---------------------------------------------------------------
  // per bit: a set in the clearing cycle survives the read
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      assign flags_d[gi] = set_vec[gi] || (flags_q[gi] && !rd_hit); // [R1] [R4] [R20]
    end
  endgenerate

  // cleared by master reset or a host read, never by soft_reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flags_q <= rpi_pkg::PENDING_RESET; // [R5]
    end else begin
      flags_q <= flags_d;
    end
  end

  // read data holds the contents before the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      host_rd_data  <= 16'h0000;
      host_rd_valid <= 1'b0;
    end else begin
      host_rd_valid <= host_rd_stb;
      if (host_rd_stb) begin
        host_rd_data <= rd_hit ? flags_q : 16'h0000; // [R4]
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt outputs
  // ---------------------------------------------------------------
  // level outputs follow pending flags, so a read drops them
  assign message_irq_out  = |(flags_q & rpi_pkg::MESSAGE_MASK);  // [R2]
  assign hardware_irq_out = |(flags_q & rpi_pkg::HARDWARE_MASK); // [R2]

  // start refused while address parity is wrong
  assign terminal_run = start_execution_bit && !parity_bad; // [R16]

  // built-in test word bit 1, sticky until master reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      init_fail_q <= 1'b0;
    end else if (rom_checksum_fault || ram_verify_fault) begin
      init_fail_q <= 1'b1; // [R19]
    end
  end
  assign bit_word_init_fail = init_fail_q;

  // ---------------------------------------------------------------
  // log feed
  // ---------------------------------------------------------------
  // simultaneous events share one entry to keep the log in step
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      log_stb_q  <= 1'b0;
      log_data_q <= 16'h0000;
    end else begin
      log_stb_q  <= |set_vec; // [R1]
      log_data_q <= set_vec;
    end
  end

  rpi_log u_log (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .entry_stb  (log_stb_q),
    .entry_data (log_data_q),
    .rd_idx     (log_rd_idx),
    .rd_data    (log_rd_data),
    .wr_ptr     (log_wr_ptr)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_read_clears;
    @(posedge clk_sys) disable iff (!resetn)
    (rd_hit && (set_vec == 16'h0000)) |=> (flags_q == 16'h0000);
  endproperty
  a_read_clears: assert property (p_read_clears) // [R4]
    else $error("pending flags not cleared after read");

  property p_read_data;
    @(posedge clk_sys) disable iff (!resetn)
    rd_hit |=> (host_rd_valid && (host_rd_data == $past(flags_q)));
  endproperty
  a_read_data: assert property (p_read_data) // [R4]
    else $error("read data is not the pre-clear contents");

  property p_set_wins;
    @(posedge clk_sys) disable iff (!resetn)
    (rd_hit && (set_vec != 16'h0000)) |=> ((flags_q & $past(set_vec)) == $past(set_vec));
  endproperty
  a_set_wins: assert property (p_set_wins) // [R20]
    else $error("event lost in clearing cycle");

  property p_unused_zero;
    @(posedge clk_sys) disable iff (!resetn)
    (flags_q & ~rpi_pkg::FLAG_IMPL_MASK) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) // [R20]
    else $error("unused flag bit set");

  property p_error_needs_enable;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(flags_q[rpi_pkg::BIT_MESSAGE_ERROR])
      |-> $past(message_error_evt && irq_enable[rpi_pkg::BIT_MESSAGE_ERROR]);
  endproperty
  a_error_needs_enable: assert property (p_error_needs_enable) // [R3]
    else $error("message error flag set without enabled event");

  property p_msg_output;
    @(posedge clk_sys) disable iff (!resetn)
    (message_error_evt && irq_enable[rpi_pkg::BIT_MESSAGE_ERROR])
      |=> message_irq_out;
  endproperty
  a_msg_output: assert property (p_msg_output) // [R2]
    else $error("message output not raised");

  property p_wrap;
    @(posedge clk_sys) disable iff (!resetn)
    ((timetag_prev_q == rpi_pkg::TIMETAG_MAX) && (timetag_count == rpi_pkg::TIMETAG_MIN)
      && irq_enable[rpi_pkg::BIT_TIMETAG_WRAP])
      |=> (flags_q[rpi_pkg::BIT_TIMETAG_WRAP] && hardware_irq_out);
  endproperty
  a_wrap: assert property (p_wrap) // [R14]
    else $error("counter wrap not flagged");

  property p_parity_flag;
    @(posedge clk_sys) disable iff (!resetn)
    (parity_bad && !parity_bad_q) |=> (flags_q[rpi_pkg::BIT_ADDR_PARITY] && log_stb_q);
  endproperty
  a_parity_flag: assert property (p_parity_flag) // [R15]
    else $error("parity fault not flagged");

  property p_no_run;
    @(posedge clk_sys) disable iff (!resetn)
    parity_bad |-> !terminal_run;
  endproperty
  a_no_run: assert property (p_no_run) // [R16]
    else $error("terminal started with parity fault");

  property p_test_word;
    @(posedge clk_sys) disable iff (!resetn)
    (rom_checksum_fault || ram_verify_fault)
      |=> (bit_word_init_fail && hardware_irq_out) ##1 bit_word_init_fail;
  endproperty
  a_test_word: assert property (p_test_word) // [R19]
    else $error("init fault not reflected in test word");

  property p_log_entry;
    @(posedge clk_sys) disable iff (!resetn)
    (set_vec != 16'h0000) |=> (log_stb_q && (log_data_q == $past(set_vec)))
      ##1 (log_wr_ptr == $past(log_wr_ptr) + 4'h1);
  endproperty
  a_log_entry: assert property (p_log_entry) // [R1]
    else $error("log entry missing for raised flag");

  property p_index_zero;
    @(posedge clk_sys) disable iff (!resetn)
    ((index_step_zero_evt || circular_done_evt) && cw_allow_index_zero
      && irq_enable[rpi_pkg::BIT_INDEX_ZERO])
      |=> (flags_q[rpi_pkg::BIT_INDEX_ZERO] && message_irq_out);
  endproperty
  a_index_zero: assert property (p_index_zero) // [R6]
    else $error("index zero event not flagged");

  property p_subaddr;
    @(posedge clk_sys) disable iff (!resetn)
    (subaddr_access_evt && cw_allow_subaddr && irq_enable[rpi_pkg::BIT_SUBADDR_ACC])
      |=> (flags_q[rpi_pkg::BIT_SUBADDR_ACC] && message_irq_out);
  endproperty
  a_subaddr: assert property (p_subaddr) // [R7]
    else $error("subaddress access not flagged");

  property p_broadcast;
    @(posedge clk_sys) disable iff (!resetn)
    (broadcast_rx_evt && cw_allow_broadcast && irq_enable[rpi_pkg::BIT_BROADCAST_RX])
      |=> (flags_q[rpi_pkg::BIT_BROADCAST_RX] && message_irq_out);
  endproperty
  a_broadcast: assert property (p_broadcast) // [R8]
    else $error("broadcast message not flagged");

  property p_illegal;
    @(posedge clk_sys) disable iff (!resetn)
    (illegal_command_evt && irq_enable[rpi_pkg::BIT_ILLEGAL_CMD])
      |=> (flags_q[rpi_pkg::BIT_ILLEGAL_CMD] && message_irq_out);
  endproperty
  a_illegal: assert property (p_illegal) // [R10]
    else $error("illegal command not flagged");

  property p_serial;
    @(posedge clk_sys) disable iff (!resetn)
    (serial_host_variant && host_serial_frame_fault && irq_enable[rpi_pkg::BIT_SERIAL_FRAME])
      |=> (flags_q[rpi_pkg::BIT_SERIAL_FRAME] && hardware_irq_out);
  endproperty
  a_serial: assert property (p_serial) // [R11]
    else $error("serial framing fault not flagged");

  property p_loopback;
    @(posedge clk_sys) disable iff (!resetn)
    (loopback_a_stb && (loopback_a_sent != loopback_a_echo)
      && irq_enable[rpi_pkg::BIT_LOOPBACK_A])
      |=> (flags_q[rpi_pkg::BIT_LOOPBACK_A] && message_irq_out);
  endproperty
  a_loopback: assert property (p_loopback) // [R12]
    else $error("loopback mismatch not flagged");

  property p_match;
    @(posedge clk_sys) disable iff (!resetn)
    ((timetag_count == timetag_utility) && (timetag_prev_q != timetag_utility)
      && irq_enable[rpi_pkg::BIT_TIMETAG_MATCH])
      |=> (flags_q[rpi_pkg::BIT_TIMETAG_MATCH] && hardware_irq_out);
  endproperty
  a_match: assert property (p_match) // [R13]
    else $error("time tag match not flagged");

  property p_soft_reset;
    @(posedge clk_sys) disable iff (!resetn)
    (soft_reset && !rd_hit && (set_vec == 16'h0000)) |=> (flags_q == $past(flags_q));
  endproperty
  a_soft_reset: assert property (p_soft_reset) // [R5]
    else $error("software reset disturbed pending flags");

endmodule
`default_nettype wire

//--- tb/rpi_host_model.sv
// host processor model: reads registers over the plain host read port
// assumes the bench clock; requests change only at falling edges
`timescale 1ns/1ns
`default_nettype none
module rpi_host_model (
  input  wire logic        clk_sys,
  output logic             host_rd_stb,
  output logic      [15:0] host_addr,
  input  wire logic [15:0] host_rd_data,
  input  wire logic        host_rd_valid
);
  // --------------------------------------------------------------
  // read cycle
  // --------------------------------------------------------------
  // idle offset is inverted so a stale address never looks valid
  initial begin
    host_rd_stb = 1'b0;
    host_addr   = 16'h5a5a;
  end

  // request held across the taking edge; data is taken with valid
  task automatic read_reg(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    host_rd_stb = 1'b1;
    host_addr   = a;
    @(negedge clk_sys);
    host_rd_stb = 1'b0;
    host_addr   = ~a;
    d = (host_rd_valid === 1'b1) ? host_rd_data : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

//--- tb/rt_pending_interrupt_flags_tb.sv
// self-checking bench for the pending-interrupt flag block
// assumes rpi_host_model performs every register read
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module rt_pending_interrupt_flags_tb;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  typedef struct {int s; logic [15:0] en; logic cw; logic sv; logic [15:0] exp;} rpi_row_type;
  logic        clk_sys = 1'b0, resetn = 1'b0, soft_reset = 1'b0;
  logic        cw = 1'b1, sv = 1'b1, stx = 1'b1;
  logic [13:0] ev = '0;
  logic [15:0] en = '0, tt_count = 16'h0100, lb_echo = 16'ha5a4, rd;
  logic [5:0]  term_bits = 6'h01;
  logic [3:0]  log_idx = '0, ptr0, log_ptr;
  logic        host_rd_stb, host_rd_valid, msg_irq, hw_irq, run, bw_fail;
  logic [15:0] host_addr, host_rd_data, log_data;
  int          errors = 0, n_checks = 0;
  // one or two rows per event source: enabled, plus a gated variant for some
  rpi_row_type rows[19] = '{
    '{0, 16'h8000, 1, 1, 16'h8000}, '{1, 16'h8000, 1, 1, 16'h8000},
    '{0, 16'h8000, 0, 1, 16'h0000}, '{2, 16'h4000, 1, 1, 16'h4000},
    '{2, 16'h4000, 0, 1, 16'h0000}, '{3, 16'h2000, 1, 1, 16'h2000},
    '{4, 16'h0400, 1, 1, 16'h0400}, '{4, 16'hfbff, 1, 1, 16'h0000},
    '{5, 16'h0100, 1, 1, 16'h0100}, '{6, 16'h0080, 1, 1, 16'h0080},
    '{6, 16'h0080, 1, 0, 16'h0000}, '{7, 16'h0040, 1, 1, 16'h0040},
    '{8, 16'h0020, 1, 1, 16'h0020}, '{9, 16'h0010, 1, 1, 16'h0010},
    '{10, 16'h0008, 1, 1, 16'h0008}, '{11, 16'h0000, 1, 1, 16'h0004},
    '{12, 16'h0000, 1, 1, 16'h0002}, '{13, 16'h0000, 1, 1, 16'h0001},
    '{3, 16'h0000, 1, 1, 16'h0000}};

  // --------------------------------------------------------------
  // design, host and clock
  // --------------------------------------------------------------
  rpi_flags i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .soft_reset(soft_reset),
    .host_rd_stb(host_rd_stb), .host_addr(host_addr), .host_rd_data(host_rd_data),
    .host_rd_valid(host_rd_valid), .irq_enable(en),
    .index_step_zero_evt(ev[0]), .circular_done_evt(ev[1]), .cw_allow_index_zero(cw),
    .subaddr_access_evt(ev[2]), .cw_allow_subaddr(cw), .broadcast_rx_evt(ev[3]),
    .cw_allow_broadcast(cw), .message_error_evt(ev[4]), .illegal_command_evt(ev[5]),
    .serial_host_variant(sv), .host_serial_frame_fault(ev[6]),
    .loopback_a_stb(ev[7]), .loopback_a_sent(16'ha5a5), .loopback_a_echo(lb_echo),
    .loopback_b_stb(ev[8]), .loopback_b_sent(16'ha5a5), .loopback_b_echo(lb_echo),
    .timetag_count(tt_count), .timetag_utility(16'h5555), .term_addr_bits(term_bits),
    .start_execution_bit(stx), .rom_checksum_fault(ev[12]), .ram_verify_fault(ev[13]),
    .message_irq_out(msg_irq), .hardware_irq_out(hw_irq), .terminal_run(run),
    .bit_word_init_fail(bw_fail), .log_rd_idx(log_idx), .log_rd_data(log_data),
    .log_wr_ptr(log_ptr)
  );

  rpi_host_model i_host (
    .clk_sys(clk_sys), .host_rd_stb(host_rd_stb), .host_addr(host_addr),
    .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid)
  );

  always #20 clk_sys = ~clk_sys;

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  // one-cycle stimulus; time tag and parity sources move levels instead
  task automatic fire(input int s);
    @(negedge clk_sys);
    case (s)
      9: tt_count = 16'h5555;
      10: tt_count = 16'hffff;
      11: term_bits = 6'h3c;
      default: ev[s] = 1'b1;
    endcase
    @(negedge clk_sys);
    ev = '0;
    tt_count = (s == 10) ? 16'h0000 : 16'h0100;
    term_bits = 6'h01;
  endtask

  // three cycles cover the wrap source, which lands one edge late
  task automatic run_row(input rpi_row_type r);
    en = r.en;
    cw = r.cw;
    sv = r.sv;
    ptr0 = log_ptr;
    fire(r.s);
    repeat (3) @(negedge clk_sys);
    `CHK("message irq", |(r.exp & rpi_pkg::MESSAGE_MASK), msg_irq)
    `CHK("hardware irq", |(r.exp & rpi_pkg::HARDWARE_MASK), hw_irq)
    `CHK("log pointer", ptr0 + 4'(r.exp != 0), log_ptr)
    log_idx = ptr0;
    @(negedge clk_sys);
    if (r.exp != 0) `CHK("log entry", r.exp, log_data)
    i_host.read_reg(rpi_pkg::PENDING_OFFSET, rd);
    `CHK("pending flags", r.exp, rd)
    `CHK("irq after read", 2'b00, {msg_irq, hw_irq})
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // --------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------
  // table rows first, then the awkward cases by hand
  initial begin
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    `CHK("reset irq", 2'b00, {msg_irq, hw_irq})
    `CHK("reset log pointer", 4'h0, log_ptr)
    foreach (rows[i]) run_row(rows[i]);
    en = 16'hffff;
    fire(4);
    soft_reset = 1'b1;
    @(negedge clk_sys);
    soft_reset = 1'b0;
    i_host.read_reg(16'h0007, rd);
    `CHK("other offset", 16'h0000, rd)
    i_host.read_reg(rpi_pkg::PENDING_OFFSET, rd);
    `CHK("after soft reset", 16'h0400, rd)
    fork
      i_host.read_reg(rpi_pkg::PENDING_OFFSET, rd);
      fire(5);
    join
    `CHK("read with event", 16'h0000, rd)
    i_host.read_reg(rpi_pkg::PENDING_OFFSET, rd);
    `CHK("kept event", 16'h0100, rd)
    lb_echo = 16'ha5a5;
    fire(7);
    fire(8);
    lb_echo = 16'ha5a4;
    i_host.read_reg(rpi_pkg::PENDING_OFFSET, rd);
    `CHK("loopback match", 16'h0000, rd)
    @(negedge clk_sys);
    term_bits = 6'h3c;
    #1 `CHK("run bad parity", 1'b0, run)
    @(negedge clk_sys);
    term_bits = 6'h01;
    #1 `CHK("run good parity", 1'b1, run)
    `CHK("test word", 1'b1, bw_fail)
    i_host.read_reg(rpi_pkg::PENDING_OFFSET, rd);
    `CHK("parity flag", 16'h0004, rd)
    fire(4);
    @(negedge clk_sys);
    resetn = 1'b0;
    @(negedge clk_sys);
    resetn = 1'b1;
    `CHK("reset test word", 1'b0, bw_fail)
    `CHK("irq after reset", 2'b00, {msg_irq, hw_irq})
    i_host.read_reg(rpi_pkg::PENDING_OFFSET, rd);
    `CHK("flags after reset", 16'h0000, rd)
    end_of_test();
  end

  // whole run is under two hundred cycles; this allows ample margin
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
